// ==== hw/eep_params.svh ====
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH

// Clock and self-timed cycle figures
`define EEP_CLK_MHZ        50
`define EEP_T_WORD_US      5000
`define EEP_T_EALL_US      6000
`define EEP_T_FALL_US      15000
`define EEP_T_SEL_LOW_NS   250
`define EEP_SEL_GAP_CYC    ((`EEP_T_SEL_LOW_NS * `EEP_CLK_MHZ + 999) / 1000)

// Frame layout
`define EEP_OPC_BITS       2
`define EEP_ABITS16        10
`define EEP_ABITS8         11
`define EEP_DBITS16        16
`define EEP_DBITS8         8
`define EEP_WORDS          512
`define EEP_LAST_WORD      9'h1FF
`define EEP_ERASED         16'hFFFF

// Register offsets
`define EEP_REG_STATUS     8'h00
`define EEP_REG_CTRL       8'h04
`define EEP_REG_MEMADDR    8'h08
`define EEP_REG_MEMDATA    8'h0C

// Field positions and reset values
`define EEP_STAT_BUSY      0
`define EEP_STAT_UNLOCKED  1
`define EEP_STAT_WIDE      2
`define EEP_STAT_ALLOW     3
`define EEP_STAT_SHOWN     4
`define EEP_CTRL_LOCK      0
`define EEP_CTRL_RESET     1'h0
`define EEP_MEMADDR_RESET  9'h000

// Bus answers
`define EEP_RESP_OKAY      2'h0
`define EEP_RESP_SLVERR    2'h2

`endif

// ==== hw/eep_pkg.sv ====
package eep_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_READ  = 3'h4
  } eep_state_type;

  typedef enum logic [1:0] {
    OPC_EXT   = 2'h0,
    OPC_WRITE = 2'h1,
    OPC_READ  = 2'h2,
    OPC_ERASE = 2'h3
  } eep_opc_type;

  typedef enum logic [1:0] {
    QUAL_LOCK      = 2'h0,
    QUAL_FILL      = 2'h1,
    QUAL_ERASE_ALL = 2'h2,
    QUAL_UNLOCK    = 2'h3
  } eep_qual_type;

  typedef enum logic [1:0] {
    KIND_WORD      = 2'h0,
    KIND_ERASE_ALL = 2'h1,
    KIND_FILL_ALL  = 2'h2
  } eep_kind_type;

  typedef struct packed {
    eep_state_type st;
    eep_opc_type   opc;
    logic [5:0]    cnt;
    logic [10:0]   addr;
    logic [15:0]   data;
    logic [9:0]    rd_addr;
    logic [15:0]   rd_sh;
    logic [4:0]    rd_cnt;
    logic          unlocked;
    logic          stat_pend;
    logic          stat_show;
    logic          stat_clr;
    logic [3:0]    gap_cnt;
    logic          sclk_d;
    logic          dout;
    logic          dout_oe;
    logic          fill_act;
    logic [8:0]    fill_idx;
    logic [8:0]    fill_last;
    logic [15:0]   fill_val;
    logic [1:0]    fill_be;
    logic          go;
    eep_kind_type  go_kind;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic          sw_lock;
    logic [8:0]    memaddr;
  } eep_regs_type;

endpackage

// ==== hw/eep_sync.sv ====
`timescale 1ns/1ps
module eep_sync
  import eep_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  logic         aclk,
  input  logic         aresetn,
  // Asynchronous levels in, synchronised levels out
  input  logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } eep_sync_type;

  eep_sync_type s;
  eep_sync_type n;

  always_comb begin
    n.meta   = async_in;
    n.stable = s.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sync_out = s.stable;

endmodule

// ==== hw/eep_timer.sv ====
`timescale 1ns/1ps
module eep_timer
  import eep_pkg::*;
(
  // Clock and reset
  input  logic        aclk,
  input  logic        aresetn,
  // Start pulse with length in cycles
  input  logic        start,
  input  logic [19:0] load,
  // Busy while counting
  output logic        busy
);

  typedef struct packed {
    logic [19:0] cnt;
    logic        busy;
  } eep_timer_type;

  eep_timer_type s;
  eep_timer_type n;

  always_comb begin
    n = s;
    if (start) begin
      n.cnt  = load;
      n.busy = 1'b1;
    end else if (s.cnt > 20'h00001) begin
      n.cnt = s.cnt - 20'h00001;
    end else begin
      n.cnt  = 20'h00000;
      n.busy = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign busy = s.busy;

endmodule

// ==== hw/eep_cmd_port.sv ====
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "eep_params.svh"
module eep_cmd_port
  import eep_pkg::*;
#(
  parameter int T_WORD_CYC = `EEP_T_WORD_US * `EEP_CLK_MHZ,
  parameter int T_EALL_CYC = `EEP_T_EALL_US * `EEP_CLK_MHZ,
  parameter int T_FALL_CYC = `EEP_T_FALL_US * `EEP_CLK_MHZ
) (
  // Clock and reset
  input  logic        aclk,
  input  logic        aresetn,
  // Serial link pins
  input  logic        select_pin,
  input  logic        serial_clk,
  input  logic        serial_in,
  output logic        serial_out,
  output logic        serial_out_oe,
  // Strap pins
  input  logic        word_width_select,
  input  logic        program_allow_pin,
  // AXI4-Lite write channels
  input  logic [7:0]  awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  // AXI4-Lite read channels
  input  logic [7:0]  araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready
);

  eep_regs_type s;
  eep_regs_type n;
  logic [15:0]  mem [0:`EEP_WORDS-1];
  logic [4:0]   pins_s;
  logic         cs_s;
  logic         sclk_s;
  logic         din_s;
  logic         w16_s;
  logic         allow_s;
  logic         rise;
  logic         busy;
  logic [19:0]  t_load;
  logic [15:0]  rd_word;

  // Every pin crosses two flops before use
  eep_sync #(.W(5)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({select_pin, serial_clk, serial_in, word_width_select, program_allow_pin}),
    .sync_out (pins_s)
  );

  assign cs_s    = pins_s[4];
  assign sclk_s  = pins_s[3];
  assign din_s   = pins_s[2];
  assign w16_s   = pins_s[1];
  assign allow_s = pins_s[0];
  assign rise    = sclk_s & ~s.sclk_d;

  always_comb begin
    case (s.go_kind)
      KIND_ERASE_ALL: t_load = 20'(T_EALL_CYC);
      KIND_FILL_ALL:  t_load = 20'(T_FALL_CYC);
      default:        t_load = 20'(T_WORD_CYC);
    endcase
  end

  // Busy keeps running when select drops
  eep_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (s.go),
    .load    (t_load),
    .busy    (busy)
  );

  // Narrow words sit in the high byte so one shifter serves both widths
  always_comb begin
    if (s.rd_addr[0] && !w16_s) begin
      rd_word = {mem[s.rd_addr[9:1]][7:0], 8'h00};
    end else if (w16_s) begin
      rd_word = mem[s.rd_addr[8:0]];
    end else begin
      rd_word = {mem[s.rd_addr[9:1]][15:8], 8'h00};
    end
  end

  always_comb begin
    logic [5:0]   cnt_n;
    logic [5:0]   hdr;
    logic [5:0]   full;
    logic [4:0]   last_bit;
    logic [10:0]  a_n;
    logic [15:0]  d_n;
    eep_qual_type q;
    logic         launch;
    eep_kind_type kind;
    logic         prog_ok;
    cnt_n    = 6'h00;
    a_n      = s.addr;
    d_n      = s.data;
    launch   = 1'b0;
    kind     = KIND_WORD;
    hdr      = w16_s ? 6'(`EEP_OPC_BITS + `EEP_ABITS16) : 6'(`EEP_OPC_BITS + `EEP_ABITS8);
    full     = w16_s ? 6'(`EEP_OPC_BITS + `EEP_ABITS16 + `EEP_DBITS16)
                     : 6'(`EEP_OPC_BITS + `EEP_ABITS8 + `EEP_DBITS8);
    last_bit = w16_s ? 5'(`EEP_DBITS16 - 1) : 5'(`EEP_DBITS8 - 1);
    q        = w16_s ? eep_qual_type'(s.addr[9:8]) : eep_qual_type'(s.addr[10:9]);
    prog_ok  = s.unlocked & allow_s & ~s.sw_lock & ~busy & ~s.fill_act;
    n        = s;
    n.go     = 1'b0;
    n.sclk_d = sclk_s;

    // Array update walks one word a clock, free of the serial clock
    if (s.fill_act) begin
      if (s.fill_idx == s.fill_last) begin
        n.fill_act = 1'b0;
      end else begin
        n.fill_idx = s.fill_idx + 9'h001;
      end
    end

    if (!cs_s) begin
      n.st      = ST_IDLE;
      n.dout_oe = 1'b0;
      n.dout    = 1'b0;
      n.cnt     = 6'h00;
      n.rd_cnt  = 5'h00;
      if (s.gap_cnt != 4'(`EEP_SEL_GAP_CYC)) begin
        n.gap_cnt = s.gap_cnt + 4'h1;
      end else if (s.stat_pend) begin
        n.stat_pend = 1'b0;
        n.stat_show = 1'b1;
      end
      if (s.stat_clr) begin
        n.stat_show = 1'b0;
        n.stat_clr  = 1'b0;
      end
    end else begin
      n.gap_cnt = 4'h0;
      case (s.st)
        ST_IDLE: begin
          n.dout_oe = s.stat_show;
          n.dout    = ~busy;
          if (rise && din_s) begin
            n.st  = ST_SHIFT;
            n.cnt = 6'h00;
            n.opc = OPC_EXT;
            if (s.stat_show && !busy) begin
              n.stat_clr = 1'b1;
            end
          end
        end
        ST_SHIFT: begin
          n.dout_oe = s.stat_show;
          n.dout    = ~busy;
          if (rise) begin
            cnt_n = s.cnt + 6'h01;
            n.cnt = cnt_n;
            if (cnt_n <= 6'(`EEP_OPC_BITS)) begin
              n.opc = eep_opc_type'({s.opc[0], din_s});
            end else if (cnt_n <= hdr) begin
              a_n    = {s.addr[9:0], din_s};
              n.addr = a_n;
            end else begin
              d_n    = {s.data[14:0], din_s};
              n.data = d_n;
            end
            if (cnt_n == hdr) begin
              q = w16_s ? eep_qual_type'(a_n[9:8]) : eep_qual_type'(a_n[10:9]);
              case (s.opc)
                OPC_READ: begin
                  n.st      = ST_READ;
                  n.dout    = 1'b0;
                  n.dout_oe = 1'b1;
                  n.rd_cnt  = 5'h00;
                  n.rd_addr = w16_s ? {1'b0, a_n[8:0]} : a_n[9:0];
                end
                OPC_ERASE: begin
                  launch = 1'b1;
                  n.st   = ST_IDLE;
                end
                OPC_EXT: begin
                  case (q)
                    QUAL_UNLOCK: begin
                      n.unlocked = 1'b1;
                      n.st       = ST_IDLE;
                    end
                    QUAL_LOCK: begin
                      n.unlocked = 1'b0;
                      n.st       = ST_IDLE;
                    end
                    QUAL_ERASE_ALL: begin
                      launch = 1'b1;
                      kind   = KIND_ERASE_ALL;
                      n.st   = ST_IDLE;
                    end
                    default: n.st = ST_SHIFT;
                  endcase
                end
                default: n.st = ST_SHIFT;
              endcase
            end else if (cnt_n == full && (s.opc == OPC_WRITE || (s.opc == OPC_EXT && q == QUAL_FILL))) begin
              launch = 1'b1;
              kind   = (s.opc == OPC_WRITE) ? KIND_WORD : KIND_FILL_ALL;
              n.st   = ST_IDLE;
            end
          end
        end
        ST_READ: begin
          n.dout_oe = 1'b1;
          if (rise) begin
            if (s.rd_cnt == 5'h00) begin
              n.dout  = rd_word[15];
              n.rd_sh = {rd_word[14:0], 1'b0};
            end else begin
              n.dout  = s.rd_sh[15];
              n.rd_sh = {s.rd_sh[14:0], 1'b0};
            end
            // Sequential read rolls on while select stays high
            if (s.rd_cnt == last_bit) begin
              n.rd_cnt  = 5'h00;
              n.rd_addr = w16_s ? {1'b0, s.rd_addr[8:0] + 9'h001} : s.rd_addr + 10'h001;
            end else begin
              n.rd_cnt = s.rd_cnt + 5'h01;
            end
          end
        end
        default: n.st = ST_IDLE;
      endcase
    end

    // Refused launches are dropped silently, like a locked part
    if (launch && prog_ok) begin
      n.go        = 1'b1;
      n.go_kind   = kind;
      n.stat_pend = 1'b1;
      n.fill_act  = 1'b1;
      if (kind == KIND_WORD) begin
        n.fill_idx  = w16_s ? a_n[8:0] : a_n[9:1];
        n.fill_last = w16_s ? a_n[8:0] : a_n[9:1];
        n.fill_be   = w16_s ? 2'h3 : (a_n[0] ? 2'h1 : 2'h2);
      end else begin
        n.fill_idx  = 9'h000;
        n.fill_last = `EEP_LAST_WORD;
        n.fill_be   = 2'h3;
      end
      if (s.opc == OPC_EXT && kind == KIND_ERASE_ALL || s.opc == OPC_ERASE) begin
        n.fill_val = `EEP_ERASED;
      end else begin
        n.fill_val = w16_s ? d_n : {d_n[7:0], d_n[7:0]};
      end
    end

    // AXI4-Lite write path
    if (awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got && !n.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `EEP_RESP_OKAY;
      case (n.awaddr)
        `EEP_REG_CTRL: begin
          if (n.wstrb[0]) n.sw_lock = n.wdata[`EEP_CTRL_LOCK];
        end
        `EEP_REG_MEMADDR: begin
          if (n.wstrb[0]) n.memaddr[7:0] = n.wdata[7:0];
          if (n.wstrb[1]) n.memaddr[8] = n.wdata[8];
        end
        `EEP_REG_STATUS, `EEP_REG_MEMDATA: n.bresp = `EEP_RESP_OKAY;
        default: n.bresp = `EEP_RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;

    // AXI4-Lite read path
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `EEP_RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      case (araddr)
        `EEP_REG_STATUS: begin
          n.rdata[`EEP_STAT_BUSY]     = busy;
          n.rdata[`EEP_STAT_UNLOCKED] = s.unlocked;
          n.rdata[`EEP_STAT_WIDE]     = w16_s;
          n.rdata[`EEP_STAT_ALLOW]    = allow_s;
          n.rdata[`EEP_STAT_SHOWN]    = s.stat_show;
        end
        `EEP_REG_CTRL:    n.rdata[`EEP_CTRL_LOCK] = s.sw_lock;
        `EEP_REG_MEMADDR: n.rdata[8:0] = s.memaddr;
        `EEP_REG_MEMDATA: n.rdata[15:0] = mem[s.memaddr];
        default:          n.rresp = `EEP_RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.sw_lock  <= `EEP_CTRL_RESET;
      s.memaddr  <= `EEP_MEMADDR_RESET;
    end else begin
      s <= n;
    end
  end

  // Array holds no reset: it stands for nonvolatile cells
  always_ff @(posedge aclk) begin
    if (s.fill_act && s.fill_be[1]) begin
      mem[s.fill_idx][15:8] <= s.fill_val[15:8];
    end
    if (s.fill_act && s.fill_be[0]) begin
      mem[s.fill_idx][7:0] <= s.fill_val[7:0];
    end
  end

  assign serial_out    = s.dout;
  assign serial_out_oe = s.dout_oe;
  assign awready       = s.awready;
  assign wready        = s.wready;
  assign bvalid        = s.bvalid;
  assign bresp         = s.bresp;
  assign arready       = s.arready;
  assign rvalid        = s.rvalid;
  assign rresp         = s.rresp;
  assign rdata         = s.rdata;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_no_start;
    (s.st == ST_IDLE && cs_s && rise && !din_s) |=> (s.st == ST_IDLE && !s.go);
  endproperty
  a_no_start: assert property (p_no_start) else $error("left idle without start bit");

  property p_start;
    (s.st == ST_IDLE && cs_s && rise && din_s) |=> (s.st == ST_SHIFT && s.cnt == 6'h00);
  endproperty
  a_start: assert property (p_start) else $error("start bit not taken");

  property p_cs_fall;
    $fell(cs_s) |=> (!serial_out_oe && s.st == ST_IDLE);
  endproperty
  a_cs_fall: assert property (p_cs_fall) else $error("output not released on select fall");

  property p_dummy;
    (s.st == ST_SHIFT) ##1 (s.st == ST_READ) |-> (!serial_out && serial_out_oe);
  endproperty
  a_dummy: assert property (p_dummy) else $error("read lacks leading zero");

  property p_hiz;
    serial_out_oe |-> (s.st == ST_READ || s.stat_show);
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven outside read or status");

  property p_status;
    (cs_s && s.st == ST_IDLE && s.stat_show) |=> (!serial_out_oe || serial_out == !$past(busy));
  endproperty
  a_status: assert property (p_status) else $error("status level wrong");

  property p_locked;
    s.go |-> ($past(s.unlocked) && !$past(s.sw_lock));
  endproperty
  a_locked: assert property (p_locked) else $error("program launched while locked");

  property p_allow;
    s.go |-> $past(allow_s);
  endproperty
  a_allow: assert property (p_allow) else $error("program launched with allow pin low");

  property p_busy;
    s.go |=> busy [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not held after launch");

  c_read: cover property ((s.st == ST_READ) ##1 (rise && s.rd_cnt == 5'h01));
  c_erase_all: cover property (s.go && s.go_kind == KIND_ERASE_ALL);
  c_status: cover property (serial_out_oe && s.st == ST_IDLE && serial_out);

endmodule

// ==== bench/eep_host_model.sv ====
`timescale 1ns/1ps
module eep_host_model (
  // Clock
  input  wire logic  aclk,
  // Link pins
  output logic       select_pin,
  output logic       serial_clk,
  output logic       serial_in,
  input  wire logic  serial_out,
  input  wire logic  serial_out_oe
);
  logic        line;
  logic        last;
  logic [31:0] rx;

  // Released wire shows inverse of last level, so stale data never passes
  assign line = serial_out_oe ? serial_out : ~last;

  always @(posedge aclk) begin
    if (serial_out_oe) begin
      last <= serial_out;
    end
  end

  initial begin
    select_pin = 1'b0;
    serial_clk = 1'b0;
    serial_in  = 1'b0;
    last       = 1'b0;
    rx         = 32'h0;
  end

  // Clock period 8 aclk; reply sampled just before each rise
  task automatic frame(input int n, input logic [31:0] v);
    @(posedge aclk);
    select_pin <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= v[i];
      repeat (4) @(posedge aclk);
      rx         <= {rx[30:0], line};
      serial_clk <= 1'b1;
      repeat (4) @(posedge aclk);
      serial_clk <= 1'b0;
    end
  endtask

  task automatic gap();
    select_pin <= 1'b0;
    serial_in  <= 1'b0;
    repeat (15) @(posedge aclk);
  endtask

  task automatic sel_hi();
    @(posedge aclk);
    select_pin <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
endmodule

// ==== bench/eep_cmd_port_bench.sv ====
`timescale 1ns/1ps
module eep_cmd_port_bench;
  logic        aclk, aresetn, word_width_select, program_allow_pin;
  logic        select_pin, serial_clk, serial_in, serial_out, serial_out_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          num_errors;
  int          checks;

  eep_cmd_port #(.T_WORD_CYC(2000), .T_EALL_CYC(2200), .T_FALL_CYC(2400)) dut_u (
    .aclk, .aresetn, .select_pin, .serial_clk, .serial_in, .serial_out, .serial_out_oe,
    .word_width_select, .program_allow_pin, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready);

  eep_host_model host_u (.aclk, .select_pin, .serial_clk, .serial_in, .serial_out, .serial_out_oe);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run();
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, 2'h0);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", rresp, er);
    chk("rdata", rdata, e);
  endtask

  // Status must show busy, then ready, then clear on start bit plus deselect
  task automatic prog_check(input int w);
    host_u.gap();
    host_u.sel_hi();
    chk("status_oe", serial_out_oe, 1'b1);
    chk("busy_level", host_u.line, 1'b0);
    axr(8'h00, 32'h0000001F, 2'h0);
    repeat (w) @(posedge aclk);
    chk("ready_level", host_u.line, 1'b1);
    host_u.frame(1, 32'h1);
    host_u.gap();
    chk("status_cleared", serial_out_oe, 1'b0);
    // Reselecting shows the flag itself dropped, not only the pin
    host_u.sel_hi();
    chk("status_gone", serial_out_oe, 1'b0);
    host_u.gap();
  endtask

  task automatic refused();
    host_u.gap();
    host_u.sel_hi();
    chk("no_status", serial_out_oe, 1'b0);
    host_u.gap();
  endtask

  task automatic t_regs();
    axr(8'h00, 32'h0000000C, 2'h0);
    axr(8'h04, 32'h0, 2'h0);
    axr(8'h10, 32'h0, 2'h2);
    axw(8'h08, 32'h5);
    axr(8'h08, 32'h5, 2'h0);
  endtask

  task automatic t_word();
    host_u.frame(13, 32'h1C05);
    refused();
    host_u.frame(13, 32'h1300);
    host_u.gap();
    axr(8'h00, 32'h0000000E, 2'h0);
    // Two leading zeros precede the start bit and must be ignored
    host_u.frame(31, 32'h1405A55A);
    prog_check(2100);
    host_u.frame(30, 32'h300A0000);
    chk("read_word", host_u.rx[16:0], 17'h0A55A);
    host_u.gap();
    host_u.frame(28, 32'h0A028000);
    host_u.gap();
    axr(8'h0C, 32'h0000A55A, 2'h0);
  endtask

  task automatic t_narrow();
    word_width_select <= 1'b0;
    host_u.gap();
    host_u.frame(23, 32'h00601400);
    chk("read_byte", host_u.rx[8:0], 9'h0A5);
    word_width_select <= 1'b1;
    host_u.gap();
  endtask

  task automatic t_bulk();
    host_u.frame(13, 32'h1C05);
    prog_check(2100);
    axr(8'h0C, 32'h0000FFFF, 2'h0);
    host_u.frame(29, 32'h11001234);
    prog_check(2500);
    axr(8'h0C, 32'h00001234, 2'h0);
    host_u.frame(13, 32'h1200);
    prog_check(2300);
    axr(8'h0C, 32'h0000FFFF, 2'h0);
    host_u.frame(13, 32'h1000);
    host_u.gap();
    host_u.frame(29, 32'h14051234);
    refused();
    host_u.frame(13, 32'h1300);
    host_u.gap();
    axw(8'h04, 32'h1);
    axr(8'h04, 32'h1, 2'h0);
    host_u.frame(29, 32'h14051234);
    refused();
    axw(8'h04, 32'h0);
    program_allow_pin <= 1'b0;
    host_u.gap();
    host_u.frame(29, 32'h14051234);
    refused();
    axr(8'h0C, 32'h0000FFFF, 2'h0);
  endtask

  initial begin
    aresetn           = 1'b0;
    word_width_select = 1'b1;
    program_allow_pin = 1'b1;
    {awaddr, araddr, wdata} = '0;
    wstrb             = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    num_errors        = 0;
    checks            = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    t_regs();
    t_word();
    t_narrow();
    t_bulk();
    complete_run();
  end

  // Whole run is well under a millisecond; twice that means a hang
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
endmodule
